// ===== sensor_two_wire_slave_port.sv
// Purpose: two-wire slave port reaching the sensor register set
// Assumes: link_clk free-running oversampling clock; SCL from master
// Notes  : register side runs on sys_clk; words cross by toggles
`timescale 1ns/1ps
`default_nettype none
`include "sensor_port_defines.svh"
module sensor_two_wire_slave_port
  import sensor_port_pkg::*;
#(
  parameter int unsigned TMO_CYCLES = `TMO_CYCLES
) (
  // System clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Link sampling clock
  input  wire logic        link_clk,
  // Bus lines
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // Address-select pins
  input  wire logic        addr_select_pin_bit0,
  input  wire logic        addr_select_pin_bit1,
  input  wire logic        addr_select_pin_bit2,
  // Register side
  output logic [2:0]       reg_ptr,
  output logic             reg_wr_strobe,
  output logic             reg_wr_msb,
  output logic [7:0]       reg_wr_byte,
  output logic             reg_rd_strobe,
  input  wire logic [15:0] reg_rd_data,
  // Mode
  output logic             high_speed_bus_mode
);

  function automatic logic [7:0] pick_byte(input logic [15:0] word,
                                           input logic        msb);
    pick_byte = msb ? word[15:8] : word[7:0];
  endfunction : pick_byte

  ////////////////////////////////////////////////////////////////////////
  // Link domain: reset, filters, conditions

  logic           rst_l1_ff;
  logic           rst_l2_ff;
  wire  [1:0]     filt;
  logic           scl_d_ff;
  logic           sda_d_ff;
  logic [2:0]     apin1_ff;
  logic [2:0]     apin2_ff;
  logic [2:0]     addr_low_ff;
  logic           tmo1_ff;
  logic           tmo2_ff;
  logic           tmo3_ff;
  logic           rack1_ff;
  logic           rack2_ff;
  logic           rack3_ff;
  logic           expire_tgl;
  link_state_type state_ff;
  logic [3:0]     cnt_ff;
  logic [7:0]     sh_ff;
  logic [7:0]     tx_ff;
  logic [2:0]     ptr_ff;
  logic           msb_sel_ff;
  logic           want_low_ff;
  logic           hs_ff;
  logic           busy_ff;
  logic [2:0]     hold_ff;
  logic           wr_tgl_ff;
  logic           wr_msb_ff;
  logic [7:0]     wr_byte_ff;
  logic           rd_tgl_ff;
  logic [15:0]    rd_word_ff;
  logic           rack_tgl_ff;
  logic [15:0]    rd_word_sys_ff;

  logic scl_f;
  logic sda_f;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic tmo_evt;
  logic rack_evt;
  logic addr_hit;
  logic [7:0] first_byte;

  always_ff @(posedge link_clk) begin
    rst_l1_ff <= rst;
    rst_l2_ff <= rst_l1_ff;
  end

  // Lines are oversampled and filtered before any edge logic
  for (genvar i = 0; i < 2; i++) begin : g_filt
    pin_filter u_filt (
      .link_clk (link_clk),
      .link_rst (rst_l2_ff),
      .pin_in   (i == 0 ? scl_in : sda_in),
      .hs_mode  (hs_ff),
      .level_ff (filt[i])
    );
  end

  assign scl_f = filt[0];
  assign sda_f = filt[1];

  always_ff @(posedge link_clk) begin
    if (rst_l2_ff) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_f;
      sda_d_ff <= sda_f;
    end
  end

  assign scl_rise   = scl_f & ~scl_d_ff;
  assign scl_fall   = ~scl_f & scl_d_ff;
  assign start_cond = scl_f & scl_d_ff & sda_d_ff & ~sda_f;
  assign stop_cond  = scl_f & scl_d_ff & ~sda_d_ff & sda_f;

  // Pins and toggles from elsewhere
  always_ff @(posedge link_clk) begin
    apin1_ff <= {addr_select_pin_bit2, addr_select_pin_bit1,
                 addr_select_pin_bit0};
    apin2_ff <= apin1_ff;
    tmo1_ff  <= expire_tgl;
    tmo2_ff  <= tmo1_ff;
    tmo3_ff  <= tmo2_ff;
    rack1_ff <= rack_tgl_ff;
    rack2_ff <= rack1_ff;
    rack3_ff <= rack2_ff;
  end

  assign tmo_evt  = tmo2_ff ^ tmo3_ff;
  assign rack_evt = rack2_ff ^ rack3_ff;
  assign addr_hit = (sh_ff[7:1] == {`ADDR_FIXED, addr_low_ff});
  assign first_byte = pick_byte(rd_word_ff, msb_sel_ff);

  // Pins are caught at each start so a rewire mid-frame is harmless
  always_ff @(posedge link_clk) begin
    if (rst_l2_ff) begin
      addr_low_ff <= 3'h0;
    end else if (start_cond) begin
      addr_low_ff <= apin2_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Link domain: bit counter and shifter

  always_ff @(posedge link_clk) begin
    if (rst_l2_ff || start_cond || stop_cond || tmo_evt) begin
      cnt_ff <= 4'h0;
    end else if (scl_rise && cnt_ff < `BIT_LAST) begin
      cnt_ff <= cnt_ff + 4'h1;
    end else if (scl_fall && cnt_ff == `BIT_LAST) begin
      cnt_ff <= 4'h0;
    end
  end

  always_ff @(posedge link_clk) begin
    if (rst_l2_ff) begin
      sh_ff <= 8'h00;
    end else if (scl_rise && cnt_ff < `BIT_ACK) begin
      sh_ff <= {sh_ff[6:0], sda_f};
    end
  end

  always_ff @(posedge link_clk) begin
    if (rst_l2_ff) begin
      rd_word_ff <= 16'h0000;
    end else if (rack_evt) begin
      rd_word_ff <= rd_word_sys_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Link domain: transfer control

  always_ff @(posedge link_clk) begin
    if (rst_l2_ff || tmo_evt) begin
      state_ff    <= ST_IDLE;
      want_low_ff <= 1'b0;
      ptr_ff      <= rst_l2_ff ? `PTR_RESET : ptr_ff;
      msb_sel_ff  <= 1'b1;
      tx_ff       <= 8'h00;
      hs_ff       <= rst_l2_ff ? 1'b0 : hs_ff;
      wr_tgl_ff   <= rst_l2_ff ? 1'b0 : wr_tgl_ff;
      wr_msb_ff   <= 1'b0;
      wr_byte_ff  <= 8'h00;
      rd_tgl_ff   <= rst_l2_ff ? 1'b0 : rd_tgl_ff;
    end else if (stop_cond) begin
      state_ff    <= ST_IDLE;
      want_low_ff <= 1'b0;
      hs_ff       <= 1'b0;
    end else if (start_cond) begin
      state_ff    <= ST_ADDR;
      want_low_ff <= 1'b0;
    end else if (scl_rise && cnt_ff == `BIT_ACK) begin
      if (state_ff == ST_RDATA && sda_f) begin
        state_ff <= ST_IGNORE;
      end
    end else if (scl_fall && cnt_ff == `BIT_ACK) begin
      unique case (state_ff)
        ST_ADDR: begin
          if (addr_hit) begin
            want_low_ff <= 1'b1;
            msb_sel_ff  <= 1'b1;
            state_ff    <= sh_ff[0] ? ST_RDATA : ST_PTR;
            if (sh_ff[0]) begin
              rd_tgl_ff <= ~rd_tgl_ff;
            end
          end else begin
            if (sh_ff[7:3] == `MCODE_PREFIX) begin
              hs_ff <= 1'b1;
            end
            state_ff <= ST_IGNORE;
          end
        end
        ST_PTR: begin
          ptr_ff      <= sh_ff[2:0];
          want_low_ff <= 1'b1;
          msb_sel_ff  <= 1'b1;
          state_ff    <= ST_WDATA;
        end
        ST_WDATA: begin
          want_low_ff <= 1'b1;
          wr_byte_ff  <= sh_ff;
          wr_msb_ff   <= msb_sel_ff;
          wr_tgl_ff   <= ~wr_tgl_ff;
          msb_sel_ff  <= ~msb_sel_ff;
        end
        ST_RDATA: begin
          want_low_ff <= 1'b0;
        end
        ST_IDLE, ST_IGNORE: begin
          want_low_ff <= 1'b0;
        end
      endcase
    end else if (scl_fall && cnt_ff == `BIT_LAST) begin
      if (state_ff == ST_RDATA) begin
        tx_ff       <= first_byte;
        want_low_ff <= ~first_byte[7];
        msb_sel_ff  <= ~msb_sel_ff;
      end else begin
        want_low_ff <= 1'b0;
      end
    end else if (scl_fall && cnt_ff != 4'h0 && cnt_ff < `BIT_ACK) begin
      if (state_ff == ST_RDATA) begin
        tx_ff       <= {tx_ff[6:0], 1'b0};
        want_low_ff <= ~tx_ff[6];
      end
    end
  end

  always_ff @(posedge link_clk) begin
    if (rst_l2_ff) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= (state_ff != ST_IDLE);
    end
  end

  // Output hold delay keeps SDA steady past the SCL fall
  always_ff @(posedge link_clk) begin
    if (rst_l2_ff) begin
      sda_oe  <= 1'b0;
      hold_ff <= 3'h0;
    end else if (want_low_ff == sda_oe) begin
      hold_ff <= 3'h0;
    end else if (hold_ff >= (hs_ff ? `HOLD_HS : `HOLD_FM)) begin
      sda_oe  <= want_low_ff;
      hold_ff <= 3'h0;
    end else begin
      hold_ff <= hold_ff + 3'h1;
    end
  end

  // Open drain: only ever pulls low
  always_ff @(posedge link_clk) begin
    sda_out <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // System domain: register side

  logic        w1_ff;
  logic        w2_ff;
  logic        w3_ff;
  logic        r1_ff;
  logic        r2_ff;
  logic        r3_ff;
  logic        hs1_ff;
  logic        rd_pend_ff;

  always_ff @(posedge sys_clk) begin
    w1_ff  <= wr_tgl_ff;
    w2_ff  <= w1_ff;
    w3_ff  <= w2_ff;
    r1_ff  <= rd_tgl_ff;
    r2_ff  <= r1_ff;
    r3_ff  <= r2_ff;
    hs1_ff <= hs_ff;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      high_speed_bus_mode <= 1'b0;
    end else begin
      high_speed_bus_mode <= hs1_ff;
    end
  end

  // Link data is held steady until the next toggle, so sampling is safe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_ptr       <= `PTR_RESET;
      reg_wr_strobe <= 1'b0;
      reg_wr_msb    <= 1'b0;
      reg_wr_byte   <= 8'h00;
      reg_rd_strobe <= 1'b0;
    end else begin
      reg_wr_strobe <= w2_ff ^ w3_ff;
      reg_rd_strobe <= r2_ff ^ r3_ff;
      if (w2_ff ^ w3_ff) begin
        reg_ptr     <= ptr_ff;
        reg_wr_msb  <= wr_msb_ff;
        reg_wr_byte <= wr_byte_ff;
      end else if (r2_ff ^ r3_ff) begin
        reg_ptr <= ptr_ff;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_pend_ff     <= 1'b0;
      rack_tgl_ff    <= 1'b0;
      rd_word_sys_ff <= 16'h0000;
    end else if (r2_ff ^ r3_ff) begin
      rd_pend_ff <= 1'b1;
    end else if (rd_pend_ff) begin
      rd_pend_ff     <= 1'b0;
      rd_word_sys_ff <= reg_rd_data;
      rack_tgl_ff    <= ~rack_tgl_ff;
    end
  end

  bus_timeout #(
    .TMO_CYCLES (TMO_CYCLES)
  ) u_tmo (
    .sys_clk       (sys_clk),
    .rst           (rst),
    .scl_in        (scl_in),
    .sda_in        (sda_in),
    .busy_in       (busy_ff),
    .expire_tgl_ff (expire_tgl)
  );

endmodule : sensor_two_wire_slave_port
`default_nettype wire

// ===== sensor_port_defines.svh
// Purpose: constants of the two-wire sensor slave port
// Assumes: included by bare name
// Notes  : counts are cycles of the clock named beside them
// Overview of operation
// - Acknowledge a write-direction address byte that matches our address.
// - Byte after a write address is the pointer; acknowledge it.
// - Store and acknowledge every data byte after the pointer.
// - Read address acknowledged: send pointed register's high byte first.
// - After master ack, send the low byte of the same register.
// - Master ack continues a read; nack, start or stop releases SDA.
// - High-speed code is not acknowledged but switches filters to high speed.
// - Slave address follows the code; high speed holds until stop.
// - Stop in high speed returns filters to fast-mode behaviour.
// - SCL or SDA low for timeout inside a frame resets and releases.
// - Start is SDA falling while SCL high; it begins address reception.
// - Stop is SDA rising while SCL high; both endings are recognised.
// - No limit on data bytes between start and stop.
// - Master may update only the high byte by ending after it.
// - Acknowledge holds SDA low through the ninth clock's high phase.
// - Low three address bits follow the address-select pins.
// - Address is seven bits plus direction; upper four bits fixed.
// - Reads use the last written pointer; pointer kept until rewritten.
// - Three low pointer bits select the data register.
// - Bytes shift most significant bit first both ways.
`ifndef SENSOR_PORT_DEFINES_SVH
`define SENSOR_PORT_DEFINES_SVH
`define ADDR_FIXED   4'h9
`define MCODE_PREFIX 5'h01
`define BIT_ACK      4'h8
`define BIT_LAST     4'h9
`define PTR_RESET    3'h0
`define SYS_CLK_HZ   40000000
`define TMO_MS       22
`define TMO_CYCLES   (`TMO_MS * (`SYS_CLK_HZ / 1000))
`define FILT_FM      3'h1
`define FILT_HS      3'h0
`define HOLD_FM      3'h4
`define HOLD_HS      3'h1
`endif

// ===== sensor_port_pkg.sv
// Purpose: types of the two-wire sensor slave port
// Assumes: nothing
// Notes  : none
package sensor_port_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_PTR, ST_WDATA, ST_RDATA, ST_IGNORE
  } link_state_type;
endpackage : sensor_port_pkg

// ===== pin_filter.sv
// Purpose: synchroniser and glitch filter for one bus line
// Assumes: runs on the link clock
// Notes  : filter depth shrinks in high-speed mode
`timescale 1ns/1ps
`default_nettype none
`include "sensor_port_defines.svh"
module pin_filter (
  // Clock and reset
  input  wire logic link_clk,
  input  wire logic link_rst,
  // Line and mode
  input  wire logic pin_in,
  input  wire logic hs_mode,
  // Filtered level
  output logic      level_ff
);
  logic       sync1_ff;
  logic       sync2_ff;
  logic [2:0] run_ff;

  always_ff @(posedge link_clk) begin
    sync1_ff <= pin_in;
    sync2_ff <= sync1_ff;
  end

  // Level must differ for two samples, or one in high-speed mode, before it is taken
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      run_ff   <= 3'h0;
      level_ff <= 1'b1;
    end else if (sync2_ff == level_ff) begin
      run_ff <= 3'h0;
    end else if (run_ff >= (hs_mode ? `FILT_HS : `FILT_FM)) begin
      level_ff <= sync2_ff;
      run_ff   <= 3'h0;
    end else begin
      run_ff <= run_ff + 3'h1;
    end
  end
endmodule : pin_filter
`default_nettype wire

// ===== bus_timeout.sv
// Purpose: bus-stuck timeout counter
// Assumes: runs on sys_clk; busy comes from the link domain
// Notes  : expiry is signalled as a toggle
`timescale 1ns/1ps
`default_nettype none
`include "sensor_port_defines.svh"
module bus_timeout #(
  parameter int unsigned TMO_CYCLES = `TMO_CYCLES
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Observed levels
  input  wire logic scl_in,
  input  wire logic sda_in,
  input  wire logic busy_in,
  // Expiry toggle
  output logic      expire_tgl_ff
);
  logic [2:0]  s1_ff;
  logic [2:0]  s2_ff;
  logic [19:0] cnt_ff;

  always_ff @(posedge sys_clk) begin
    s1_ff <= {busy_in, sda_in, scl_in};
    s2_ff <= s1_ff;
  end

  // Only counts inside a frame, so an idle low bus does not trip it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_ff        <= 20'h00000;
      expire_tgl_ff <= 1'b0;
    end else if (!s2_ff[2] || (s2_ff[1] && s2_ff[0])) begin
      cnt_ff <= 20'h00000;
    end else if (cnt_ff == 20'(TMO_CYCLES - 1)) begin
      cnt_ff        <= 20'h00000;
      expire_tgl_ff <= ~expire_tgl_ff;
    end else begin
      cnt_ff <= cnt_ff + 20'h00001;
    end
  end
endmodule : bus_timeout
`default_nettype wire

// ===== port_checker_sva.sv
// Purpose: port checker of the two-wire slave port
// Assumes: bound to the top module, sees its ports only
// Notes  : timeout bound leaves slack for the domain crossing
`timescale 1ns/1ps
`default_nettype none
module port_checker #(
  parameter int unsigned TMO_CYCLES = 2000
) (
  // Clocks and reset
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       link_clk,
  // Bus
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  // Register side
  input wire logic [2:0] reg_ptr,
  input wire logic       reg_wr_strobe,
  input wire logic       reg_wr_msb,
  input wire logic [7:0] reg_wr_byte,
  input wire logic       reg_rd_strobe,
  input wire logic       high_speed_bus_mode
);
  logic [31:0] low_cnt_ff;
  logic        last_msb_ff;
  always_ff @(posedge sys_clk) begin
    if (rst || scl_in) low_cnt_ff <= 32'h0;
    else if (low_cnt_ff != 32'hffffffff) low_cnt_ff <= low_cnt_ff + 32'h1;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) last_msb_ff <= 1'b0;
    else if (reg_wr_strobe) last_msb_ff <= reg_wr_msb;
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_sda_open_drain: assert property (@(posedge link_clk) disable iff (rst)
    sda_out == 1'b0) else $error("sda_out driven high");
  a_oe_scl_low: assert property (@(posedge link_clk) disable iff (rst)
    $changed(sda_oe) |-> !scl_in) else $error("sda_oe changed while SCL high");
  a_wr_strobe_pulse: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr_strobe |=> !reg_wr_strobe [*8]) else $error("write strobe too long");
  a_rd_strobe_pulse: assert property (@(posedge sys_clk) disable iff (rst)
    reg_rd_strobe |=> !reg_rd_strobe [*8]) else $error("read strobe too long");
  a_strobe_excl: assert property (@(posedge sys_clk) disable iff (rst)
    !(reg_wr_strobe && reg_rd_strobe)) else $error("both strobes at once");
  a_wr_byte_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !reg_wr_strobe |-> $stable(reg_wr_byte) && $stable(reg_wr_msb))
    else $error("write byte moved without strobe");
  a_ptr_hold_rd: assert property (@(posedge sys_clk) disable iff (rst)
    reg_rd_strobe |=> $stable(reg_ptr)) else $error("pointer moved during read fetch");
  a_msb_order: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr_strobe && !reg_wr_msb |-> last_msb_ff) else $error("low byte without high byte");
  a_hs_stop_idle: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(high_speed_bus_mode) |-> scl_in && sda_in) else $error("high speed left mid frame");
  a_tmo_release: assert property (@(posedge sys_clk) disable iff (rst)
    low_cnt_ff > TMO_CYCLES + 100 |-> !sda_oe) else $error("bus not released on timeout");
endmodule : port_checker
bind sensor_two_wire_slave_port port_checker #(.TMO_CYCLES(TMO_CYCLES)) chk (
  .sys_clk(sys_clk), .rst(rst), .link_clk(link_clk), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .reg_ptr(reg_ptr), .reg_wr_strobe(reg_wr_strobe),
  .reg_wr_msb(reg_wr_msb), .reg_wr_byte(reg_wr_byte), .reg_rd_strobe(reg_rd_strobe),
  .high_speed_bus_mode(high_speed_bus_mode));
`default_nettype wire

// ===== two_wire_master_model.sv
// Purpose: behavioural two-wire bus master
// Assumes: SDA pulled up; wire level returns on sda_wire
// Notes  : half period kept well above filter and answer delays
`timescale 1ns/1ps
`default_nettype none
module two_wire_master_model #(
  parameter int HP = 1300
) (
  // Bus
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_wire
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // Also serves as repeated start when SCL is low
  task automatic bus_start;
    sda_drv = 1'b1;
    #(HP/2) scl = 1'b1;
    #(HP/2) sda_drv = 1'b0;
    #(HP/2) scl = 1'b0;
    #(HP/2);
  endtask : bus_start
  task automatic bus_stop;
    sda_drv = 1'b0;
    #(HP/2) scl = 1'b1;
    #(HP/2) sda_drv = 1'b1;
    #HP;
  endtask : bus_stop
  // Period below 400 kHz, far above the minimum rate
  task automatic bit_x(input logic b, output logic s);
    sda_drv = b;
    #(HP/2) scl = 1'b1;
    #(HP/2) s = sda_wire;
    #(HP/2) scl = 1'b0;
    #(HP/2);
  endtask : bit_x
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(d[i], s);
    bit_x(1'b1, s);
    ack = ~s;
  endtask : wbyte
  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(~mack, s);
  endtask : rbyte
endmodule : two_wire_master_model
`default_nettype wire

// ===== testbench.sv
// Purpose: self-checking bench of the two-wire slave port
// Assumes: bench acts as register set and bus master
// Notes  : timeout shortened to TMO cycles to keep the run short
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int unsigned TMO = 2000;
  logic        sys_clk = 1'b0, link_clk = 1'b0, rst = 1'b1;
  logic        scl, sda_drv, sda_wire, sda_out, sda_oe, wr_stb, wr_msb, rd_stb, hs;
  logic [2:0]  pins = 3'h0, ptr, rd_ptr;
  logic [7:0]  wr_byte;
  logic [15:0] rd_data = 16'h0;
  logic [15:0] regs [8];
  logic [11:0] wq [$];
  int          n_mismatch = 0, checked = 0, cyc = 0, n_rd = 0;
  always #12.5 sys_clk = ~sys_clk;
  always #40 link_clk = ~link_clk;
  assign sda_wire = sda_drv & ~(sda_oe & ~sda_out);
  two_wire_master_model m (.scl(scl), .sda_drv(sda_drv), .sda_wire(sda_wire));
  sensor_two_wire_slave_port #(.TMO_CYCLES(TMO)) dut (
    .sys_clk(sys_clk), .rst(rst), .link_clk(link_clk), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_pin_bit0(pins[0]),
    .addr_select_pin_bit1(pins[1]), .addr_select_pin_bit2(pins[2]), .reg_ptr(ptr),
    .reg_wr_strobe(wr_stb), .reg_wr_msb(wr_msb), .reg_wr_byte(wr_byte),
    .reg_rd_strobe(rd_stb), .reg_rd_data(rd_data), .high_speed_bus_mode(hs));
  always @(negedge sys_clk) begin
    rd_data <= regs[ptr];
    if (wr_stb === 1'b1) wq.push_back({ptr, wr_msb, wr_byte});
    if (rd_stb === 1'b1) begin
      n_rd++;
      rd_ptr <= ptr;
    end
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_mismatch++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_bit(string nm, logic e, logic g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  task automatic chk_val(string nm, logic [15:0] e, logic [15:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_val
  // Expected values come from the bench's own register copy and the sent words
  function automatic logic [15:0] exp_rd(logic [2:0] p, int i);
    exp_rd = 16'(i[0] ? regs[p][7:0] : regs[p][15:8]);
  endfunction : exp_rd
  function automatic logic [15:0] exp_wr(logic [2:0] p, int i, logic [15:0] d);
    exp_wr = {4'h0, p, ~i[0], i[0] ? d[7:0] : d[15:8]};
  endfunction : exp_wr
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  task automatic wr_tx(logic [2:0] a, logic [7:0] pb, int n, logic [15:0] d, logic stp);
    logic ack;
    logic [7:0] b;
    wq.delete();
    m.bus_start();
    m.wbyte({4'h9, a, 1'b0}, ack);
    chk_bit("addr_ack", 1'b1, ack);
    m.wbyte(pb, ack);
    chk_bit("ptr_ack", 1'b1, ack);
    for (int i = 0; i < n; i++) begin
      b = i[0] ? d[7:0] : d[15:8];
      m.wbyte(b, ack);
      chk_bit("data_ack", 1'b1, ack);
      if (i[0]) regs[pb[2:0]][7:0] = b;
      else regs[pb[2:0]][15:8] = b;
    end
    if (stp) m.bus_stop();
    repeat (20) @(negedge sys_clk);
    chk_val("wr_count", 16'(n), 16'(wq.size()));
    for (int i = 0; i < n && i < wq.size(); i++)
      chk_val("wr_entry", exp_wr(pb[2:0], i, d), 16'(wq[i]));
  endtask : wr_tx
  task automatic rd_tx(logic [2:0] a, logic [2:0] p, int n);
    logic ack;
    logic [7:0] b;
    int r0;
    r0 = n_rd;
    m.bus_start();
    m.wbyte({4'h9, a, 1'b1}, ack);
    chk_bit("rd_addr_ack", 1'b1, ack);
    for (int i = 0; i < n; i++) begin
      m.rbyte(i < n - 1, b);
      chk_val("rd_byte", exp_rd(p, i), 16'(b));
    end
    #500;
    chk_bit("rd_release", 1'b0, sda_oe);
    chk_val("rd_ptr", 16'(p), 16'(rd_ptr));
    chk_val("rd_strobes", 16'h1, 16'(n_rd - r0));
    m.bus_stop();
  endtask : rd_tx
  task automatic set_pins(logic [2:0] v);
    @(negedge sys_clk) pins = v;
  endtask : set_pins
  initial begin
    logic [2:0] a, p;
    logic [7:0] ab;
    logic ack;
    void'($urandom(95));
    for (int i = 0; i < 8; i++) regs[i] = 16'($urandom);
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    repeat (16) @(negedge sys_clk);
    for (int k = 0; k < 5; k++) begin
      a = 3'($urandom);
      p = 3'($urandom);
      set_pins(a);
      wr_tx(a, {5'($urandom), p}, k % 4, 16'($urandom), k != 2);
      rd_tx(a, p, 2 + k % 2);
    end
    wq.delete();
    m.bus_start();
    m.wbyte({4'h9, a ^ 3'h5, 1'b0}, ack);
    chk_bit("foreign_nack", 1'b0, ack);
    m.wbyte(8'h01, ack);
    chk_bit("ignored_nack", 1'b0, ack);
    m.bus_stop();
    chk_val("ignored_wr", 16'h0, 16'(wq.size()));
    m.bus_start();
    m.wbyte({5'h01, 3'($urandom)}, ack);
    chk_bit("hs_nack", 1'b0, ack);
    repeat (20) @(negedge sys_clk);
    chk_bit("hs_on", 1'b1, hs);
    p = 3'($urandom);
    wr_tx(a, {5'h00, p}, 2, 16'($urandom), 1'b0);
    chk_bit("hs_hold", 1'b1, hs);
    m.bus_stop();
    repeat (40) @(negedge sys_clk);
    chk_bit("hs_off", 1'b0, hs);
    ab = {4'h9, a, 1'b0};
    m.bus_start();
    for (int i = 7; i >= 0; i--) m.bit_x(ab[i], ack);
    #900;
    chk_bit("ack_drive", 1'b1, sda_oe);
    repeat (TMO + 200) @(negedge sys_clk);
    chk_bit("tmo_release", 1'b0, sda_oe);
    m.bus_stop();
    rd_tx(a, p, 2);
    test_done();
  end
endmodule : testbench
`default_nettype wire
